// >>> design/tsync_cfg_bank.sv
// Static configuration and status bank of the time sync slave, AHB-Lite slave
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module tsync_cfg_bank
	import tsync_cfg_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Parser side status sources
	input wire logic serial_rx,
	input wire logic [SEC_W-1:0] parsed_sec,
	input wire logic [NS_W-1:0] parsed_ns,
	input wire logic parsed_jump,
	input wire logic parsed_valid,
	input wire logic [LEAP_W-1:0] leap_offset_value,
	input wire logic leap_offset_qualified,
	input wire logic short_minute_flag,
	input wire logic long_minute_flag,
	input wire logic leap_from_utc_sentence,
	input wire logic leap_valid,
	input wire logic [7:0] fix_type,
	input wire logic position_solution_good,
	input wire logic [1:0] spoof_monitor_code,
	input wire logic solution_info_qualified,
	input wire logic [1:0] interference_level_code,
	input wire logic [7:0] cw_interference_scale,
	input wire logic [2:0] rf_input_condition,
	input wire logic rf_info_qualified,
	input wire logic [7:0] sats_visible_count,
	input wire logic [7:0] sats_tracked_count,
	input wire logic sat_counts_qualified,
	input wire logic health_valid,
	// Outputs toward the core
	output logic core_enable,
	output logic serial_rx_norm,
	output logic [1:0] protocol_sel,
	output logic [GNSS_W-1:0] gnss_sel,
	output logic [MASK_W-1:0] message_suppress_mask,
	output logic [20:0] baud_divider,
	output logic [SEC_W-1:0] corr_time_sec,
	output logic [NS_W-1:0] corr_time_ns,
	output logic [FRAC_W-1:0] corr_time_frac,
	output logic corr_time_sign,
	output logic corr_time_jump,
	output logic corr_time_valid,
	output logic adj_valid,
	output logic [IVL_W-1:0] adj_interval,
	output logic core_state_qualified,
	output logic leap_info_qualified,
	output logic receiver_health_qualified
);
	// ****************************************
	// Bus slave
	// ****************************************
	logic wr_pend_q;
	logic [7:0] addr_q;
	logic [31:0] control_q;
	logic [MASK_W-1:0] suppress_q;
	logic [31:0] corr_sec_q;
	logic [31:0] corr_ns_q;
	logic [31:0] adj_ivl_q;
	logic [31:0] rd_d;
	logic [SEC_W-1:0] time_sec_q;
	logic [NS_W-1:0] time_ns_q;
	logic [LEAP_W+2:0] leap_q;
	logic [25:0] health_q;
	logic [16:0] sats_q;
	logic [FRAC_W-1:0] corr_frac;
	logic corr_sign;
	logic [3:0] rate_code;
	logic [1:0] proto;
	logic health_proto;
	logic leap_proto;
	logic [20:0] div_d;
	logic take;

	assign take = hsel && hready && htrans[1];
	assign corr_frac = control_q[CTL_CORR_FRAC_LSB +: FRAC_W];
	assign corr_sign = control_q[CTL_CORR_SIGN];
	assign rate_code = control_q[CTL_RATE_LSB +: RATE_W];
	assign proto = control_q[CTL_PROTO_LSB +: PROTO_W];
	assign health_proto = (proto == PROTO_UBX) || (proto == PROTO_TSIP);

	// Zero wait states: write data lands in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			addr_q <= 8'h00;
		end else begin
			wr_pend_q <= take && hwrite;
			if (take) begin
				addr_q <= {haddr[7:2], 2'b00};
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			control_q <= CONTROL_RST;
			suppress_q <= SUPPRESS_RST;
			corr_sec_q <= ZERO_RST;
			corr_ns_q <= ZERO_RST;
			adj_ivl_q <= ZERO_RST;
		end else if (wr_pend_q) begin
			if (addr_q == ADDR_CONTROL) begin
				control_q <= hwdata;
			end else if (addr_q == ADDR_SUPPRESS) begin
				suppress_q <= hwdata[MASK_W-1:0];
			end else if (addr_q == ADDR_CORR_SEC) begin
				corr_sec_q <= hwdata;
			end else if (addr_q == ADDR_CORR_NS) begin
				corr_ns_q <= hwdata;
			end else if (addr_q == ADDR_ADJ_IVL) begin
				adj_ivl_q <= hwdata;
			end
		end
	end

	// Read data registered at address phase so it stands in data phase
	always_comb begin
		rd_d = UNMAPPED_DATA;
		if (haddr[7:0] == ADDR_CONTROL) begin
			rd_d = control_q;
		end else if (haddr[7:0] == ADDR_SUPPRESS) begin
			rd_d = {24'h000000, suppress_q};
		end else if (haddr[7:0] == ADDR_CORR_SEC) begin
			rd_d = corr_sec_q;
		end else if (haddr[7:0] == ADDR_CORR_NS) begin
			rd_d = corr_ns_q;
		end else if (haddr[7:0] == ADDR_BAUD_DIV) begin
			rd_d = {11'h000, baud_divider};
		end else if (haddr[7:0] == ADDR_STATUS) begin
			rd_d = {29'h0, receiver_health_qualified, leap_info_qualified,
				core_state_qualified};
		end else if (haddr[7:0] == ADDR_TIME_SEC) begin
			rd_d = corr_time_sec;
		end else if (haddr[7:0] == ADDR_TIME_NS) begin
			rd_d = corr_time_ns;
		end else if (haddr[7:0] == ADDR_LEAP) begin
			rd_d = {13'h0000, leap_q};
		end else if (haddr[7:0] == ADDR_HEALTH) begin
			rd_d = {6'h00, health_q};
		end else if (haddr[7:0] == ADDR_SATS) begin
			rd_d = {15'h0000, sats_q};
		end else if (haddr[7:0] == ADDR_ADJ_IVL) begin
			rd_d = adj_ivl_q;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= ZERO_RST;
		end else if (take && !hwrite) begin
			hrdata <= rd_d;
		end
	end

	// ****************************************
	// Configuration outputs
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			core_enable <= 1'b0;
			protocol_sel <= 2'b00;
			gnss_sel <= GNSS_ANY;
			message_suppress_mask <= SUPPRESS_RST;
			adj_valid <= 1'b0;
			adj_interval <= ZERO_RST;
		end else begin
			core_enable <= control_q[CTL_ENABLE];
			protocol_sel <= proto;
			// Codes above five are unknown; treat as any
			gnss_sel <= (control_q[CTL_GNSS_LSB +: GNSS_W] > GNSS_BEIDOU) ?
				GNSS_ANY : control_q[CTL_GNSS_LSB +: GNSS_W];
			// Bits 5..7 only mean something under ESIP
			message_suppress_mask <= (proto == PROTO_ESIP) ? suppress_q :
				{3'b000, suppress_q[4:0]};
			// NMEA and ESIP share no UTC sentence meaning for bit 2
			if (proto == PROTO_ESIP) begin
				message_suppress_mask[2] <= 1'b0;
			end
			adj_valid <= control_q[CTL_ENABLE];
			adj_interval <= adj_valid ? adj_ivl_q : ZERO_RST;
		end
	end

	// Serial receive with selectable polarity
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			serial_rx_norm <= 1'b1;
		end else begin
			serial_rx_norm <= control_q[CTL_POLARITY] ? serial_rx : ~serial_rx;
		end
	end

	// Baud divider from rate code, clock 200 MHz
	always_comb begin
		case (rate_code)
			4'h0: div_d = 21'd166667;
			4'h1: div_d = 21'd83333;
			4'h2: div_d = 21'd41667;
			4'h3: div_d = 21'd20833;
			4'h4: div_d = 21'd10417;
			4'h5: div_d = 21'd5208;
			4'h6: div_d = 21'd3472;
			4'h7: div_d = 21'd1736;
			4'h8: div_d = 21'd868;
			4'h9: div_d = 21'd434;
			4'ha: div_d = 21'd217;
			4'hb: div_d = 21'd200;
			4'hc: div_d = 21'd100;
			default: div_d = 21'd1736;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			baud_divider <= 21'd1736;
		end else begin
			baud_divider <= div_d;
		end
	end

	// ****************************************
	// Time correction
	// ****************************************
	// Nanosecond carry folded into seconds; sign selects subtract
	logic [32:0] ns_sum;
	logic [31:0] ns_fix;
	logic carry;
	always_comb begin
		ns_sum = 33'h0;
		ns_fix = 32'h0;
		carry = 1'b0;
		if (!corr_sign) begin
			ns_sum = {1'b0, parsed_ns} + {1'b0, corr_ns_q};
			carry = ns_sum >= 33'd1000000000;
			ns_fix = carry ? 32'(ns_sum - 33'd1000000000) : ns_sum[31:0];
		end else begin
			carry = parsed_ns < corr_ns_q;
			ns_fix = carry ? 32'(parsed_ns + 32'd1000000000 - corr_ns_q) :
				32'(parsed_ns - corr_ns_q);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			corr_time_sec <= ZERO_RST;
			corr_time_ns <= ZERO_RST;
			corr_time_frac <= 2'b00;
			corr_time_sign <= 1'b0;
			corr_time_jump <= 1'b0;
			corr_time_valid <= 1'b0;
		end else begin
			corr_time_valid <= parsed_valid && core_enable;
			if (parsed_valid && core_enable) begin
				corr_time_sec <= corr_sign ? 32'(parsed_sec - corr_sec_q - {31'h0, carry}) :
					32'(parsed_sec + corr_sec_q + {31'h0, carry});
				corr_time_ns <= ns_fix;
				corr_time_frac <= corr_frac;
				corr_time_sign <= 1'b0;
				corr_time_jump <= parsed_jump;
			end else begin
				corr_time_jump <= 1'b0;
			end
		end
	end

	// ****************************************
	// Status capture
	// ****************************************
	assign leap_proto = (proto != PROTO_NMEA) || leap_from_utc_sentence;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			leap_q <= '0;
			health_q <= '0;
			sats_q <= '0;
		end else begin
			leap_q <= {long_minute_flag, short_minute_flag, leap_offset_qualified,
				leap_offset_value};
			if (health_proto && health_valid) begin
				health_q <= {rf_info_qualified, solution_info_qualified, spoof_monitor_code,
					(fix_type > FIX_MAX) ? FIX_MAX : fix_type, position_solution_good,
					cw_interference_scale, interference_level_code,
					rf_input_condition};
				sats_q <= {sat_counts_qualified, sats_tracked_count,
					sats_visible_count};
			end else if (!health_proto) begin
				health_q <= '0;
				sats_q <= '0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			core_state_qualified <= 1'b0;
			leap_info_qualified <= 1'b0;
			receiver_health_qualified <= 1'b0;
		end else begin
			core_state_qualified <= core_enable;
			leap_info_qualified <= core_enable && leap_valid && leap_proto;
			receiver_health_qualified <= core_enable && health_valid && health_proto;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_enable_follows: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(control_q[CTL_ENABLE]) |-> ##1 core_enable ##1 core_state_qualified)
		else $error("enable did not reach core");
	a_health_proto_only: assert property (@(posedge hclk) disable iff (!hresetn)
		receiver_health_qualified |-> $past(health_proto))
		else $error("health qualified under wrong protocol");
	a_polarity_path: assert property (@(posedge hclk) disable iff (!hresetn)
		!control_q[CTL_POLARITY] |=> serial_rx_norm == !$past(serial_rx))
		else $error("polarity inversion wrong");
	a_esip_mask_only: assert property (@(posedge hclk) disable iff (!hresetn)
		proto != PROTO_ESIP |=> message_suppress_mask[7:5] == 3'b000)
		else $error("upper mask bits outside esip");
	a_leap_proto: assert property (@(posedge hclk) disable iff (!hresetn)
		leap_info_qualified |-> $past(leap_proto) && $past(leap_valid))
		else $error("leap qualified without source");
	a_corr_gated: assert property (@(posedge hclk) disable iff (!hresetn)
		corr_time_valid |-> $past(core_enable) && $past(parsed_valid))
		else $error("corrected time while inactive");
	a_rate_fast: assert property (@(posedge hclk) disable iff (!hresetn)
		rate_code == 4'h7 |=> baud_divider == 21'd1736)
		else $error("rate code seven wrong divider");
	a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
		hreadyout && !hresp)
		else $error("slave not ready or error");
endmodule // tsync_cfg_bank

// >>> design/tsync_cfg_pkg.sv
// Package of field layouts, codes and register map for the time sync config bank
package tsync_cfg_pkg;
	// ****************************************
	// Record widths
	// ****************************************
	localparam int SEC_W = 32;
	localparam int NS_W = 32;
	localparam int FRAC_W = 2;
	localparam int LEAP_W = 16;
	localparam int IVL_W = 32;
	localparam int MASK_W = 8;
	localparam int PROTO_W = 2;
	localparam int GNSS_W = 4;
	localparam int RATE_W = 4;
	// ****************************************
	// Codes
	// ****************************************
	typedef enum logic [1:0] {
		PROTO_NMEA = 2'b00,
		PROTO_UBX = 2'b01,
		PROTO_TSIP = 2'b10,
		PROTO_ESIP = 2'b11
	} proto_type;
	localparam logic [3:0] GNSS_ANY = 4'h0;
	localparam logic [3:0] GNSS_COMBINED = 4'h1;
	localparam logic [3:0] GNSS_GPS = 4'h2;
	localparam logic [3:0] GNSS_GLONASS = 4'h3;
	localparam logic [3:0] GNSS_GALILEO = 4'h4;
	localparam logic [3:0] GNSS_BEIDOU = 4'h5;
	localparam logic [3:0] RATE_CODE_MAX = 4'hc;
	localparam logic [7:0] FIX_MAX = 8'h04;
	localparam logic [1:0] SPOOF_MAX = 2'h2;
	localparam logic [2:0] ANT_MAX = 3'h4;
	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_SUPPRESS = 8'h04;
	localparam logic [7:0] ADDR_CORR_SEC = 8'h08;
	localparam logic [7:0] ADDR_CORR_NS = 8'h0c;
	localparam logic [7:0] ADDR_BAUD_DIV = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_TIME_SEC = 8'h18;
	localparam logic [7:0] ADDR_TIME_NS = 8'h1c;
	localparam logic [7:0] ADDR_LEAP = 8'h20;
	localparam logic [7:0] ADDR_HEALTH = 8'h24;
	localparam logic [7:0] ADDR_SATS = 8'h28;
	localparam logic [7:0] ADDR_ADJ_IVL = 8'h2c;
	// Control field positions
	localparam int CTL_ENABLE = 0;
	localparam int CTL_POLARITY = 1;
	localparam int CTL_PROTO_LSB = 4;
	localparam int CTL_GNSS_LSB = 8;
	localparam int CTL_RATE_LSB = 12;
	localparam int CTL_CORR_FRAC_LSB = 16;
	localparam int CTL_CORR_SIGN = 18;
	// Reset values
	localparam logic [31:0] CONTROL_RST = 32'h0000_7002;
	localparam logic [31:0] ZERO_RST = 32'h0000_0000;
	localparam logic [7:0] SUPPRESS_RST = 8'h00;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// >>> testbench/gnss_feed_model.sv
// Parser-side model feeding parsed time and receiver status to the bank
`timescale 1ns/1ps
module gnss_feed_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic send,
	input wire logic [31:0] t_sec,
	input wire logic [31:0] t_ns,
	input wire logic t_jump,
	input wire logic status_on,
	input wire logic utc_sentence,
	output logic [31:0] parsed_sec,
	output logic [31:0] parsed_ns,
	output logic parsed_jump,
	output logic parsed_valid,
	output logic [15:0] leap_offset_value,
	output logic leap_offset_qualified,
	output logic short_minute_flag,
	output logic long_minute_flag,
	output logic leap_from_utc_sentence,
	output logic leap_valid,
	output logic [7:0] fix_type,
	output logic position_solution_good,
	output logic [1:0] spoof_monitor_code,
	output logic solution_info_qualified,
	output logic [1:0] interference_level_code,
	output logic [7:0] cw_interference_scale,
	output logic [2:0] rf_input_condition,
	output logic rf_info_qualified,
	output logic [7:0] sats_visible_count,
	output logic [7:0] sats_tracked_count,
	output logic sat_counts_qualified,
	output logic health_valid
);
	// ****************
	// Parsed time
	// ****************
	// Between pulses the lines flip each cycle so stale data never looks held
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			parsed_valid <= 1'b0;
			parsed_jump <= 1'b0;
			parsed_sec <= 32'h0000_0000;
			parsed_ns <= 32'h0000_0000;
		end else begin
			parsed_valid <= send;
			parsed_jump <= send ? t_jump : ~parsed_jump;
			parsed_sec <= send ? t_sec : ~parsed_sec;
			parsed_ns <= send ? t_ns : ~parsed_ns;
		end
	end
	// ****************
	// Receiver status levels
	// ****************
	assign leap_offset_value = 16'h0025;
	assign leap_offset_qualified = status_on;
	assign short_minute_flag = 1'b0;
	assign long_minute_flag = status_on;
	assign leap_from_utc_sentence = utc_sentence;
	assign leap_valid = status_on;
	assign fix_type = 8'h09;
	assign position_solution_good = status_on;
	assign spoof_monitor_code = 2'h2;
	assign solution_info_qualified = status_on;
	assign interference_level_code = 2'h3;
	assign cw_interference_scale = 8'hff;
	assign rf_input_condition = 3'h4;
	assign rf_info_qualified = status_on;
	assign sats_visible_count = 8'h0c;
	assign sats_tracked_count = 8'h09;
	assign sat_counts_qualified = status_on;
	assign health_valid = status_on;
endmodule // gnss_feed_model

// >>> testbench/testbench.sv
// Self-checking bench of the time sync configuration and status bank
`timescale 1ns/1ps
module testbench;
	import tsync_cfg_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, serial_rx, send, t_jump;
	logic [31:0] haddr, hwdata, hrdata, t_sec, t_ns, parsed_sec, parsed_ns, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic status_on, utc_sentence, parsed_jump, parsed_valid;
	logic [15:0] leap_offset_value;
	logic leap_offset_qualified, short_minute_flag, long_minute_flag, leap_from_utc_sentence;
	logic leap_valid, position_solution_good, solution_info_qualified, rf_info_qualified;
	logic [7:0] fix_type, cw_interference_scale, sats_visible_count, sats_tracked_count;
	logic [1:0] spoof_monitor_code, interference_level_code, protocol_sel, p;
	logic [2:0] rf_input_condition;
	logic sat_counts_qualified, health_valid, core_enable, serial_rx_norm, corr_time_sign;
	logic corr_time_jump, corr_time_valid, adj_valid, hv, lv;
	logic core_state_qualified, leap_info_qualified, receiver_health_qualified;
	logic [3:0] gnss_sel;
	logic [7:0] message_suppress_mask, m;
	logic [20:0] baud_divider;
	logic [31:0] corr_time_sec, corr_time_ns, adj_interval;
	logic [1:0] corr_time_frac;
	int err_count = 0;
	int n_compared = 0;
	int rates[13] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200, 230400, 460800,
		921600, 1000000, 2000000};

	tsync_cfg_bank tsync_cfg_bank_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.serial_rx(serial_rx), .parsed_sec(parsed_sec), .parsed_ns(parsed_ns),
		.parsed_jump(parsed_jump), .parsed_valid(parsed_valid),
		.leap_offset_value(leap_offset_value), .leap_offset_qualified(leap_offset_qualified),
		.short_minute_flag(short_minute_flag), .long_minute_flag(long_minute_flag),
		.leap_from_utc_sentence(leap_from_utc_sentence), .leap_valid(leap_valid),
		.fix_type(fix_type), .position_solution_good(position_solution_good),
		.spoof_monitor_code(spoof_monitor_code), .solution_info_qualified(solution_info_qualified),
		.interference_level_code(interference_level_code),
		.cw_interference_scale(cw_interference_scale), .rf_input_condition(rf_input_condition),
		.rf_info_qualified(rf_info_qualified), .sats_visible_count(sats_visible_count),
		.sats_tracked_count(sats_tracked_count), .sat_counts_qualified(sat_counts_qualified),
		.health_valid(health_valid), .core_enable(core_enable), .serial_rx_norm(serial_rx_norm),
		.protocol_sel(protocol_sel), .gnss_sel(gnss_sel),
		.message_suppress_mask(message_suppress_mask), .baud_divider(baud_divider),
		.corr_time_sec(corr_time_sec), .corr_time_ns(corr_time_ns),
		.corr_time_frac(corr_time_frac), .corr_time_sign(corr_time_sign),
		.corr_time_jump(corr_time_jump), .corr_time_valid(corr_time_valid),
		.adj_valid(adj_valid), .adj_interval(adj_interval),
		.core_state_qualified(core_state_qualified), .leap_info_qualified(leap_info_qualified),
		.receiver_health_qualified(receiver_health_qualified));

	gnss_feed_model gnss_feed_model_i (.hclk(hclk), .hresetn(hresetn), .send(send),
		.t_sec(t_sec), .t_ns(t_ns), .t_jump(t_jump), .status_on(status_on),
		.utc_sentence(utc_sentence), .parsed_sec(parsed_sec), .parsed_ns(parsed_ns),
		.parsed_jump(parsed_jump), .parsed_valid(parsed_valid),
		.leap_offset_value(leap_offset_value), .leap_offset_qualified(leap_offset_qualified),
		.short_minute_flag(short_minute_flag), .long_minute_flag(long_minute_flag),
		.leap_from_utc_sentence(leap_from_utc_sentence), .leap_valid(leap_valid),
		.fix_type(fix_type), .position_solution_good(position_solution_good),
		.spoof_monitor_code(spoof_monitor_code), .solution_info_qualified(solution_info_qualified),
		.interference_level_code(interference_level_code),
		.cw_interference_scale(cw_interference_scale), .rf_input_condition(rf_input_condition),
		.rf_info_qualified(rf_info_qualified), .sats_visible_count(sats_visible_count),
		.sats_tracked_count(sats_tracked_count), .sat_counts_qualified(sat_counts_qualified),
		.health_valid(health_valid));

	// ****************
	// Shared tasks
	// ****************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Single transfer; waits on ready in both phases, no fixed latency assumed
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0000_0000);
		check(what, rd, exp);
		check("resp", {31'h0, hresp}, 32'h0);
	endtask

	task automatic settle();
		repeat (3) @(posedge hclk);
		#1;
	endtask

	function automatic logic [31:0] ctl(input logic [1:0] pr, input logic [3:0] g,
		input logic [3:0] r, input logic pol, input logic sgn);
		return {13'h0000, sgn, 2'b10, r, g, 2'b00, pr, 2'b00, pol, 1'b1};
	endfunction

	// Sends one parsed time and compares the corrected result
	task automatic stamp(input logic sgn, input logic [31:0] es, input logic [31:0] en);
		@(posedge hclk);
		send <= 1'b1;
		t_sec <= 32'd1000;
		t_ns <= 32'd5000;
		t_jump <= 1'b1;
		@(posedge hclk);
		send <= 1'b0;
		for (int i = 0; i < 20 && corr_time_valid !== 1'b1; i++) begin
			@(posedge hclk);
			#1;
		end
		check("time valid", {31'h0, corr_time_valid}, 32'h1);
		check("time sec", corr_time_sec, es);
		check("time ns", corr_time_ns, en);
		check("time sign", {31'h0, corr_time_sign}, 32'h0);
		check("time frac", {30'h0, corr_time_frac}, 32'h2);
		check("time jump", {31'h0, corr_time_jump}, 32'h1);
	endtask

	// ****************
	// Clock, watchdog, tests
	// ****************
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	initial begin
		repeat (20000) @(posedge hclk);
		err_count++;
		summarize();
	end

	initial begin
		hresetn = 1'b0;
		{hsel, hwrite, htrans, haddr, hwdata, send, t_sec, t_ns, t_jump, utc_sentence} = '0;
		hsize = 3'b010;
		serial_rx = 1'b1;
		status_on = 1'b1;
		repeat (16) @(posedge hclk);
		check("rst div", {11'h0, baud_divider}, 32'd1736);
		check("rst rx", {31'h0, serial_rx_norm}, 32'h1);
		check("rst en", {31'h0, core_enable}, 32'h0);
		hresetn <= 1'b1;
		rdchk(ADDR_CONTROL, CONTROL_RST, "ctl rst");
		rdchk(ADDR_SUPPRESS, ZERO_RST, "mask rst");
		for (int r = 0; r < 13; r++) begin
			bus(1'b1, ADDR_CONTROL, ctl(PROTO_UBX, 4'h0, r[3:0], 1'b1, 1'b0));
			settle();
			check("div", {31'h0, baud_divider >= 200_000_000 / rates[r] &&
				baud_divider <= 200_000_000 / rates[r] + 1}, 32'h1);
			rdchk(ADDR_BAUD_DIV, 32'((200_000_000 + rates[r] / 2) / rates[r]), "div read");
		end
		for (int k = 0; k < 16; k++) begin
			p = k[3] ? PROTO_ESIP : PROTO_UBX;
			bus(1'b1, ADDR_CONTROL, ctl(p, 4'h0, 4'h7, 1'b1, 1'b0));
			bus(1'b1, ADDR_SUPPRESS, 32'h1 << k[2:0]);
			settle();
			m = 8'h01 << k[2:0];
			// Upper bits only mean something under ESIP; bit 2 has no ESIP message
			if ((!k[3] && k[2:0] > 3'd4) || (k[3] && k[2:0] == 3'd2))
				m = 8'h00;
			check("mask", {24'h0, message_suppress_mask}, {24'h0, m});
		end
		bus(1'b1, ADDR_SUPPRESS, 32'h0);
		for (int g = 0; g < 8; g++) begin
			p = g[1:0];
			bus(1'b1, ADDR_CONTROL, ctl(p, g[3:0], 4'h7, 1'b1, 1'b0));
			settle();
			hv = (p == PROTO_UBX || p == PROTO_TSIP);
			lv = (p != PROTO_NMEA);
			check("proto", {30'h0, protocol_sel}, {30'h0, p});
			check("gnss", {28'h0, gnss_sel}, (g > 5) ? 32'h0 : g);
			check("health q", {31'h0, receiver_health_qualified}, {31'h0, hv});
			check("leap q", {31'h0, leap_info_qualified}, {31'h0, lv});
			rdchk(ADDR_SATS, hv ? 32'h0001_090c : 32'h0, "sats");
			rdchk(ADDR_STATUS, {29'h0, hv, lv, 1'b1}, "status");
			rdchk(ADDR_HEALTH, hv ? 32'h0381_3ffc : 32'h0, "health");
			if (hv)
				rdchk(ADDR_LEAP, 32'h0005_0025, "leap");
		end
		bus(1'b1, ADDR_CONTROL, ctl(PROTO_NMEA, 4'h0, 4'h7, 1'b1, 1'b0));
		utc_sentence <= 1'b1;
		settle();
		check("utc sentence", {31'h0, leap_info_qualified}, 32'h1);
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, ADDR_CONTROL, ctl(PROTO_NMEA, 4'h0, 4'h7, k[1], 1'b0));
			serial_rx <= k[0];
			settle();
			check("rx norm", {31'h0, serial_rx_norm}, {31'h0, k[0] ~^ k[1]});
		end
		bus(1'b1, ADDR_CORR_SEC, 32'd10);
		bus(1'b1, ADDR_CORR_NS, 32'd100);
		bus(1'b1, ADDR_CONTROL, ctl(PROTO_UBX, 4'h0, 4'h7, 1'b1, 1'b0));
		stamp(1'b0, 32'd1010, 32'd5100);
		rdchk(ADDR_TIME_SEC, 32'd1010, "time read");
		bus(1'b1, ADDR_CONTROL, ctl(PROTO_UBX, 4'h0, 4'h7, 1'b1, 1'b1));
		stamp(1'b1, 32'd990, 32'd4900);
		bus(1'b1, ADDR_ADJ_IVL, 32'h1234_5678);
		bus(1'b1, ADDR_CONTROL, ctl(PROTO_UBX, 4'h0, 4'h7, 1'b1, 1'b0) & 32'hffff_fffe);
		settle();
		check("dis en", {30'h0, core_enable, adj_valid}, 32'h0);
		check("dis core q", {31'h0, core_state_qualified}, 32'h0);
		bus(1'b1, ADDR_CONTROL, ctl(PROTO_UBX, 4'h0, 4'h7, 1'b1, 1'b0));
		settle();
		check("en", {29'h0, core_enable, adj_valid, core_state_qualified}, 32'h7);
		check("interval", adj_interval, 32'h1234_5678);
		rdchk(8'h30, UNMAPPED_DATA, "unmapped");
		bus(1'b1, ADDR_BAUD_DIV, 32'h0);
		rdchk(ADDR_BAUD_DIV, 32'd1736, "div ro");
		summarize();
	end
endmodule // testbench
